/* touch_key_regs.svh */
`ifndef TOUCH_KEY_REGS_SVH
`define TOUCH_KEY_REGS_SVH

// register offsets on the local port
`define TK_OFS_CTRL 8'h00
`define TK_OFS_CNT_LO 8'h01
`define TK_OFS_CNT_HI 8'h02
`define TK_OFS_IRQ_STAT 8'h03
`define TK_OFS_IRQ_MASK 8'h04

// control register fields
`define TK_CTRL_FLAG_BIT 7
`define TK_CTRL_PERIOD_BIT 4
`define TK_CTRL_CHAN_LSB 0
`define TK_CTRL_RESET 8'h00

// upper count byte fields
`define TK_HI_CHANGE_BIT 7
`define TK_CNT_HI_RESET 8'h00

// interrupt status and mask bits
`define TK_IRQ_CYCLE_BIT 0
`define TK_IRQ_CHANGE_BIT 1
`define TK_IRQ_RESET 2'h0

// timing in its own units
`define TK_CLK_MHZ 100
`define TK_PERIOD_SHORT_US 1000
`define TK_PERIOD_LONG_US 2000
`define TK_PREP_US 87

// derived cycle counts
`define TK_PERIOD_SHORT_CYC (`TK_PERIOD_SHORT_US * `TK_CLK_MHZ)
`define TK_PERIOD_LONG_CYC (`TK_PERIOD_LONG_US * `TK_CLK_MHZ)
`define TK_PREP_CYC (`TK_PREP_US * `TK_CLK_MHZ)

`endif

/* touch_key_pkg.sv */
package touch_key_pkg;

  // channel field codes
  typedef enum logic [2:0] {
    CHAN_OFF = 3'h0,
    CHAN_IN0 = 3'h1,
    CHAN_IN5 = 3'h6,
    CHAN_NONE = 3'h7
  } chan_code_t;

  // timing phase, one-hot
  typedef enum logic [1:0] {
    PH_PREP = 2'h1,
    PH_DETECT = 2'h2
  } phase_t;

  // software settings held in the control register
  typedef struct packed {
    logic period_select;
    logic [2:0] chan;
  } ctrl_t;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

endpackage

/* touch_key_counter.sv */
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/100ps
`include "touch_key_regs.svh"
// Notes on behaviour
// - count is cleared, both bytes, when preparation ends
// - during detection the count rises on each sensed edge, holding at its maximum
// - during preparation the count holds for the handler
// - flag and interrupt raised as preparation starts; count kept 87 us
// - more capacitance slows the sense input, giving a smaller count
// - any control register write clears the flag and its request
// - period bit picks 1 ms or 2 ms; first 87 us is preparation
// - channel 0 powers off, 1 to 6 select inputs, 7 no input
// - write during detection sets change flag, skips this cycle's flag
// - change flag is bit 7 of high byte, cleared when preparation ends
module touch_key_counter
  import touch_key_pkg::*;
#(
  parameter int CNT_W = 14,
  parameter int N_CHAN = 6,
  parameter int PERIOD_SHORT_CYC = `TK_PERIOD_SHORT_CYC,
  parameter int PERIOD_LONG_CYC = `TK_PERIOD_LONG_CYC,
  parameter int PREP_CYC = `TK_PREP_CYC
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // register port
  input wire bus_req_t bus_i,
  output logic [7:0] rd_data_o,
  // interrupt
  output logic irq_o,
  // touch sense inputs, pulse train per electrode
  input wire logic [N_CHAN-1:0] sense_i,
  // analog front end control
  output logic module_power_o,
  output logic [N_CHAN-1:0] chan_connect_o
);

  localparam int TMR_W = $clog2(PERIOD_LONG_CYC + 1);
  localparam logic [TMR_W-1:0] PREP_LAST = TMR_W'(PREP_CYC - 1);
  localparam logic [TMR_W-1:0] SHORT_LAST = TMR_W'(PERIOD_SHORT_CYC - 1);
  localparam logic [TMR_W-1:0] LONG_LAST = TMR_W'(PERIOD_LONG_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_MAX = '1;

  // channel code to one-hot connect vector, zero for off and none
  function automatic logic [N_CHAN-1:0] chan_onehot(input logic [2:0] c);
    logic [N_CHAN-1:0] v;
    v = '0;
    if (c >= CHAN_IN0 && c <= CHAN_IN5) begin
      v[c - 3'h1] = 1'b1;
    end
    return v;
  endfunction

  // state
  ctrl_t ctrl_q;
  logic cycle_flag_q;
  logic change_q;
  logic [CNT_W-1:0] count_q;
  logic [TMR_W-1:0] timer_q;
  phase_t phase_q;
  logic sense_prev_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;

  // address decode
  wire logic wr_ctrl = bus_i.wr && bus_i.addr == `TK_OFS_CTRL;
  wire logic wr_stat = bus_i.wr && bus_i.addr == `TK_OFS_IRQ_STAT;
  wire logic wr_mask = bus_i.wr && bus_i.addr == `TK_OFS_IRQ_MASK;

  // cycle timing
  wire logic [TMR_W-1:0] period_last =
    ctrl_q.period_select ? LONG_LAST : SHORT_LAST;
  wire logic cycle_end = timer_q >= period_last;
  wire logic prep_end = phase_q == PH_PREP && timer_q == PREP_LAST;
  wire logic in_detect = phase_q == PH_DETECT;

  // sense edge on the selected channel
  wire logic [N_CHAN-1:0] sel_vec = chan_onehot(ctrl_q.chan);
  wire logic sense_sel = |(sense_i & sel_vec);
  wire logic sense_edge = sense_sel && !sense_prev_q;
  wire logic count_step =
    in_detect && sense_edge && count_q != CNT_MAX;

  // events
  wire logic change_set = wr_ctrl && in_detect;
  wire logic flag_set = cycle_end && !change_q && !change_set;
  wire logic skip_evt = cycle_end && (change_q || change_set);
  wire logic [1:0] irq_evt = {skip_evt, flag_set};

  // read mux
  wire logic [7:0] ctrl_rd = {cycle_flag_q, 2'h0, ctrl_q.period_select,
                              1'b0, ctrl_q.chan};
  wire logic [7:0] hi_rd = {change_q, 1'b0,
                            count_q[CNT_W-1:8]};
  wire logic [7:0] rd_mux =
    bus_i.addr == `TK_OFS_CTRL ? ctrl_rd :
    bus_i.addr == `TK_OFS_CNT_LO ? count_q[7:0] :
    bus_i.addr == `TK_OFS_CNT_HI ? hi_rd :
    bus_i.addr == `TK_OFS_IRQ_STAT ? {6'h0, irq_stat_q} :
    bus_i.addr == `TK_OFS_IRQ_MASK ? {6'h0, irq_mask_q} : 8'h00;
  // status clears: write one, or any control write drops the cycle request
  wire logic [1:0] irq_clr = (wr_stat ? bus_i.wdata[1:0] : 2'h0) |
    {1'b0, wr_ctrl};
  // a new event in the same cycle wins over either clear
  wire logic [1:0] irq_stat_d = irq_evt | (irq_stat_q & ~irq_clr);

  // control register
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= ctrl_t'(4'h0);
    end else if (wr_ctrl) begin
      ctrl_q.period_select <= bus_i.wdata[`TK_CTRL_PERIOD_BIT];
      ctrl_q.chan <= bus_i.wdata[`TK_CTRL_CHAN_LSB +: 3];
    end
  end

  // cycle timer and phase
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      timer_q <= '0;
      phase_q <= PH_PREP;
    end else if (cycle_end) begin
      timer_q <= '0;
      phase_q <= PH_PREP;
    end else begin
      timer_q <= timer_q + TMR_W'(1);
      if (prep_end) begin
        phase_q <= PH_DETECT;
      end
    end
  end

  // cycle-complete flag, set wins over write clear
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cycle_flag_q <= 1'b0;
    end else if (flag_set) begin
      cycle_flag_q <= 1'b1;
    end else if (wr_ctrl || prep_end) begin
      cycle_flag_q <= 1'b0;
    end
  end

  // change flag, set wins over end-of-preparation clear
  // a rewrite mid-detection may spoil the count, so its flag is withheld
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      change_q <= 1'b0;
    end else if (change_set) begin
      change_q <= 1'b1;
    end else if (prep_end) begin
      change_q <= 1'b0;
    end
  end

  // capacitance counter: fewer sensed edges for a larger load
  // edges, not levels, are counted so a long pulse counts once
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_q <= '0;
      sense_prev_q <= 1'b0;
    end else begin
      sense_prev_q <= sense_sel;
      if (prep_end) begin
        count_q <= '0;
      end else if (count_step) begin
        count_q <= count_q + CNT_W'(1);
      end
    end
  end

  // interrupt status, mask and output
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_stat_q <= `TK_IRQ_RESET;
      irq_mask_q <= `TK_IRQ_RESET;
      irq_o <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      if (wr_mask) begin
        irq_mask_q <= bus_i.wdata[1:0];
      end
      irq_o <= |(irq_stat_q & irq_mask_q);
    end
  end

  // read data and front end outputs
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o <= 8'h00;
      module_power_o <= 1'b0;
      chan_connect_o <= '0;
    end else begin
      rd_data_o <= bus_i.rd ? rd_mux : 8'h00;
      module_power_o <= ctrl_q.chan != CHAN_OFF;
      chan_connect_o <= sel_vec;
    end
  end

  // checks
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  // counter, flag and phase checks
  a_count_clear: assert property (
    prep_end |=> count_q == '0)
    else $error("count not cleared at end of preparation");

  a_count_step: assert property (
    count_step && !prep_end |=> count_q == $past(count_q) + CNT_W'(1))
    else $error("count did not step on sensed edge");

  a_count_hold: assert property (
    phase_q == PH_PREP && !prep_end |=> $stable(count_q))
    else $error("count changed during preparation");

  a_flag_raise: assert property (
    flag_set |=> cycle_flag_q && phase_q == PH_PREP && timer_q == '0)
    else $error("flag not raised at start of preparation");

  a_write_clears: assert property (
    wr_ctrl && !flag_set |=> !cycle_flag_q)
    else $error("control write did not clear flag");

  a_prep_length: assert property (
    cycle_end |=> phase_q == PH_PREP [*8])
    else $error("preparation shorter than expected");

  a_chan_decode: assert property (
    ##1 $countones(chan_connect_o) ==
      (($past(ctrl_q.chan) == CHAN_OFF ||
        $past(ctrl_q.chan) == CHAN_NONE) ? 0 : 1))
    else $error("channel connect decode wrong");

  a_change_skip: assert property (
    change_q && cycle_end |=> !cycle_flag_q && irq_stat_q[1])
    else $error("changed cycle still raised flag");

  a_change_clear: assert property (
    prep_end |=> !change_q)
    else $error("change flag survived preparation end");

  a_irq_level: assert property (
    ##1 irq_o == $past(|(irq_stat_q & irq_mask_q)))
    else $error("interrupt output mismatch");

  // register port, interrupt and decode checks
  a_write_drops_irq: assert property (
    wr_ctrl && !flag_set |=> !irq_stat_q[`TK_IRQ_CYCLE_BIT])
    else $error("control write left the cycle request pending");

  a_status_w1c: assert property (
    wr_stat && bus_i.wdata[0] && !flag_set |=> !irq_stat_q[0])
    else $error("status bit survived a write of one");

  a_change_set: assert property (
    change_set |=> change_q)
    else $error("write during detection did not mark change");

  a_write_skip: assert property (
    change_set && cycle_end |=> !cycle_flag_q && irq_stat_q[1])
    else $error("late write still raised the flag");

  a_high_byte: assert property (
    bus_i.rd && bus_i.addr == `TK_OFS_CNT_HI |=>
      rd_data_o == {$past(change_q), 1'b0, $past(count_q[CNT_W-1:8])})
    else $error("high count byte read wrong");

  a_low_byte: assert property (
    bus_i.rd && bus_i.addr == `TK_OFS_CNT_LO |=>
      rd_data_o == $past(count_q[7:0]))
    else $error("low count byte read wrong");

  a_read_idle: assert property (
    !bus_i.rd |=> rd_data_o == 8'h00)
    else $error("read data not zero outside a read");

  a_unmapped_zero: assert property (
    bus_i.rd && bus_i.addr > `TK_OFS_IRQ_MASK |=> rd_data_o == 8'h00)
    else $error("unmapped offset read not zero");

  a_power_decode: assert property (
    ##1 module_power_o == ($past(ctrl_q.chan) != CHAN_OFF))
    else $error("module power decode wrong");

  a_prep_flag_clear: assert property (
    prep_end |=> !cycle_flag_q)
    else $error("cycle flag survived preparation end");

  a_phase_window: assert property (
    (phase_q == PH_PREP) == (timer_q <= PREP_LAST))
    else $error("phase does not match the cycle timer");

  // main scenarios reached
  c_flag_seen: cover property (flag_set ##1 cycle_flag_q);
  c_skip_seen: cover property (change_set ##[1:1000] skip_evt);
  c_irq_seen: cover property ($rose(irq_o));
  c_long_period: cover property (ctrl_q.period_select && cycle_end);
  c_write_clear: cover property (wr_ctrl && cycle_flag_q);

endmodule

/* touch_electrodes.sv */
`timescale 1ns/100ps
module touch_electrodes (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // finger present per electrode
  input wire logic [5:0] touched_i,
  // sense pulse trains
  output logic [5:0] sense_o
);
  logic [3:0] ph_q [6];
  // one pulse a period; a finger adds load and slows it
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    for (int k = 0; k < 6; k++) begin
      if (rst_i)
        ph_q[k] <= 4'h0;
      else if (ph_q[k] >= (touched_i[k] ? 4'h8 : 4'h4))
        ph_q[k] <= 4'h0;
      else
        ph_q[k] <= ph_q[k] + 4'h1;
    end
  end
  // pin driven by the electrode only, no pull-up
  always_comb begin
    for (int k = 0; k < 6; k++) sense_o[k] = (ph_q[k] == 4'h0);
  end
endmodule

/* tb_touch_key_counter.sv */
`timescale 1ns/100ps
module tb_touch_key_counter;
  import touch_key_pkg::*;
  typedef struct {logic [7:0] a, e, m;} note_t;
  logic sys_clk_i = 0;
  logic rst_i = 1;
  bus_req_t bus_q = '0;
  logic [5:0] touched_q = 6'h0;
  logic [5:0] sense, conn;
  logic [7:0] rd_data, last_rd;
  logic irq, pwr;
  logic rd_pend = 0;
  logic [13:0] cnt_a, cnt_b;
  note_t notes[$];
  note_t nt;
  int fail_count = 0, n_compared = 0, cyc = 0, t0;

  touch_key_counter #(.PERIOD_SHORT_CYC(200), .PERIOD_LONG_CYC(400),
    .PREP_CYC(20)) touch_key_counter_i (.sys_clk_i(sys_clk_i),
    .rst_i(rst_i), .bus_i(bus_q), .rd_data_o(rd_data), .irq_o(irq),
    .sense_i(sense), .module_power_o(pwr), .chan_connect_o(conn));
  touch_electrodes touch_electrodes_i (.sys_clk_i(sys_clk_i),
    .rst_i(rst_i), .touched_i(touched_q), .sense_o(sense));

  initial forever #5 sys_clk_i = ~sys_clk_i;

  task automatic check(string n, logic [15:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, d);
    @(posedge sys_clk_i);
    bus_q <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk_i);
    bus_q.wr <= 1'b0;
  endtask
  // read, noting expected bits under mask m
  task automatic rd(logic [7:0] a, e = 8'h00, m = 8'h00);
    @(posedge sys_clk_i);
    bus_q <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    notes.push_back('{a, e, m});
    @(posedge sys_clk_i);
    bus_q.rd <= 1'b0;
    @(posedge sys_clk_i);
    #1;
  endtask
  task automatic rd_cnt(output logic [13:0] c);
    logic [7:0] lo;
    rd(8'h01);
    lo = last_rd;
    rd(8'h02, 8'h00, 8'h40);
    c = {last_rd[5:0], lo};
  endtask
  task automatic wait_irq;
    repeat (3) @(posedge sys_clk_i);
    for (int i = 0; i < 600 && irq !== 1'b1; i++) begin
      @(posedge sys_clk_i);
      #1;
    end
    check("irq_o", irq, 1'b1);
  endtask

  // read data checked one cycle after the strobe; hang limit
  always @(posedge sys_clk_i) begin
    cyc++;
    if (rd_pend) begin
      nt = notes.pop_front();
      last_rd = rd_data;
      if (nt.m != 0)
        check($sformatf("reg %h", nt.a), rd_data & nt.m, nt.e & nt.m);
    end
    rd_pend <= bus_q.rd;
    if (cyc == 6000) begin
      fail_count++;
      complete_run();
    end
  end

  initial begin
    void'($urandom(63));
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 6; a++) rd(a[7:0], 8'h00, 8'hff);
    for (int c = 0; c < 8; c++) begin
      wr(8'h00, c[7:0]);
      @(posedge sys_clk_i);
      #1;
      check("conn", conn, (c > 0 && c < 7) ? 6'h1 << (c - 1) : 6'h0);
      check("power", pwr, c != 0);
    end
    $display("test reset and codes done");
    wr(8'h00, 8'h01);
    wr(8'h04, 8'h01);
    wr(8'h03, 8'h03);
    wait_irq();
    rd(8'h00, 8'h80, 8'h80);
    rd_cnt(cnt_a);
    rd(8'h01, cnt_a[7:0], 8'hff);
    check("count", cnt_a >= 34 && cnt_a <= 38, 1'b1);
    wr(8'h00, 8'h01);
    rd(8'h00, 8'h00, 8'h80);
    check("irq_o", irq, 1'b0);
    wr(8'h03, 8'h01);
    repeat (2) @(posedge sys_clk_i);
    #1;
    check("irq_o", irq, 1'b0);
    rd_cnt(cnt_b);
    check("cleared", cnt_b <= 4, 1'b1);
    $display("test cycle done");
    @(posedge sys_clk_i);
    touched_q <= 6'h01 | (6'($urandom) & 6'h3e);
    wait_irq();
    wr(8'h03, 8'h01);
    wait_irq();
    rd_cnt(cnt_b);
    check("touch", cnt_b >= 18 && cnt_b <= 22 && cnt_b < cnt_a, 1'b1);
    $display("test touch done");
    wr(8'h04, 8'h03);
    wr(8'h03, 8'h03);
    repeat (30 + $urandom % 100) @(posedge sys_clk_i);
    wr(8'h00, 8'h01);
    rd(8'h02, 8'h80, 8'h80);
    wait_irq();
    rd(8'h03, 8'h02, 8'h03);
    rd(8'h02, 8'h80, 8'h80);
    wr(8'h03, 8'h03);
    wait_irq();
    t0 = cyc;
    rd(8'h03, 8'h01, 8'h03);
    rd(8'h02, 8'h00, 8'h80);
    $display("test change done");
    wr(8'h03, 8'h03);
    wait_irq();
    check("short", 16'(cyc - t0), 16'd200);
    t0 = cyc;
    wr(8'h00, 8'h11);
    wr(8'h03, 8'h03);
    wait_irq();
    check("long", 16'(cyc - t0), 16'd400);
    $display("test period done");
    complete_run();
  end
endmodule
